//--- include/ebc_map.svh
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses on the register port)
`define EBC_OFS_CLK_CTRL 8'h00
`define EBC_OFS_SPACE_CTRL 8'h04
`define EBC_OFS_STRAP_STAT 8'h08

// ==========================================================================
// Field positions
`define EBC_CLK_RATIO_LSB 0
`define EBC_SPACE_TYPE_LSB 0
`define EBC_SPACE_REN_LSB 8
`define EBC_SPACE_CTRL_W 12
`define EBC_STAT_ENDIAN 0
`define EBC_STAT_BOOT_LSB 1
`define EBC_STAT_PSEL_LSB 3
`define EBC_STAT_SSEL_LSB 5
`define EBC_STAT_DONE 7
`define EBC_STAT_READY 8
`define EBC_STAT_SRC_LSB 9

// ==========================================================================
// Strap positions on the address pins, pin n sits at index n-1
`define EBC_STRAP_ENDIAN 19
`define EBC_STRAP_BOOT_LSB 17
`define EBC_STRAP_PSEL_LSB 15
`define EBC_STRAP_SSEL_LSB 13
`define EBC_STRAP_MIN_W 20

// ==========================================================================
// Reset values and the reserved ratio code
`define EBC_RST_ENDIAN 1'b1
`define EBC_RST_BOOT 2'h2
`define EBC_RST_PSEL 2'h0
`define EBC_RST_SSEL 2'h0
`define EBC_RST_SPACE_CTRL 12'h000
`define EBC_RATIO_RESERVED 2'h3

// ==========================================================================
// Internal clock divide counts and the FIFO space number
`define EBC_CPU4_DIV 4
`define EBC_CPU6_DIV 6
`define EBC_FIFO_SPACE 2'h3

`endif

//--- include/ebc_pkg.sv
package ebc_pkg;

  // ========================================================================
  // Modes
  typedef enum logic [1:0] {
    EBC_SRC_EXT,
    EBC_SRC_CPU4,
    EBC_SRC_CPU6
  } ebc_src_t;

  typedef enum logic [1:0] {
    EBC_DIV_1,
    EBC_DIV_2,
    EBC_DIV_4
  } ebc_div_t;

  typedef enum logic [1:0] {
    EBC_MEM_ASYNC,
    EBC_MEM_SDRAM,
    EBC_MEM_SYNC,
    EBC_MEM_NONE
  } ebc_mem_t;

  // ========================================================================
  // Strobe requests from the bus engine, active high
  typedef struct packed {
    logic async_re;
    logic sdram_cas;
    logic sync_ads;
    logic sync_re;
    logic async_oe;
    logic sdram_ras;
    logic sync_oe;
    logic async_we;
    logic sdram_we;
    logic sync_we;
  } ebc_strobe_t;

  // ========================================================================
  // Module state
  typedef struct packed {
    logic [2:0] cnt;
    logic prev;
    logic [1:0] dcnt;
    logic full;
    logic div;
    logic tick;
  } ebc_clk_state_t;

  typedef struct packed {
    logic rd_n;
    logic oe_n;
    logic we_n;
    logic fifo_oe_n;
  } ebc_mux_state_t;

endpackage

//--- include/ebc_core_if.sv
`timescale 1ns/1ps

interface ebc_core_if;
  import ebc_pkg::*;

  // ========================================================================
  // Clock generation
  ebc_src_t src_sel;
  ebc_div_t ratio;
  logic ext_level;
  logic tick;
  logic full_clk;
  logic div_clk;

  // ========================================================================
  // Strobe steering
  logic acc_active;
  logic [1:0] acc_space;
  ebc_mem_t acc_mem;
  logic ren_sel;
  ebc_strobe_t strobes;
  logic rd_n;
  logic oe_n;
  logic we_n;
  logic fifo_oe_n;

  modport top_mp (
    output src_sel, ratio, ext_level, acc_active, acc_space, acc_mem,
    output ren_sel, strobes,
    input tick, full_clk, div_clk, rd_n, oe_n, we_n, fifo_oe_n
  );

  modport clk_mp (
    input src_sel, ratio, ext_level,
    output tick, full_clk, div_clk
  );

  modport mux_mp (
    input tick, acc_active, acc_space, acc_mem, ren_sel, strobes,
    output rd_n, oe_n, we_n, fifo_oe_n
  );

endinterface

//--- rtl/ebc_clk_gen.sv
`timescale 1ns/1ps
`include "ebc_map.svh"

module ebc_clk_gen (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Core link
  ebc_core_if.clk_mp io
);
  import ebc_pkg::*;

  ebc_clk_state_t s_reg;
  ebc_clk_state_t s_next;
  logic lvl;
  logic [2:0] last;

  // ========================================================================
  // Source level, edge tick and division
  // The source is fixed once the straps are taken, so no glitch-free
  // switch is needed between sources.
  always_comb begin
    s_next = s_reg;
    lvl = io.ext_level;
    last = 3'h0;
    case (io.src_sel)
      EBC_SRC_CPU4: begin
        last = 3'(`EBC_CPU4_DIV - 1);
        lvl = (s_reg.cnt < 3'(`EBC_CPU4_DIV / 2));
      end
      EBC_SRC_CPU6: begin
        last = 3'(`EBC_CPU6_DIV - 1);
        lvl = (s_reg.cnt < 3'(`EBC_CPU6_DIV / 2));
      end
      default: begin
        last = 3'h0;
        lvl = io.ext_level;
      end
    endcase
    s_next.cnt = (s_reg.cnt >= last) ? 3'h0 : s_reg.cnt + 3'h1;
    s_next.prev = lvl;
    s_next.tick = lvl & ~s_reg.prev;
    if (lvl && !s_reg.prev) begin
      s_next.dcnt = s_reg.dcnt + 2'h1;
    end
    s_next.full = lvl;
    // A ratio written mid-period only lets the divided clock rise at the next rising edge, so
    // the divided clock never rises off a full-rate clock rise.
    case (io.ratio)
      EBC_DIV_1: s_next.div = lvl && (s_next.tick || s_reg.div);
      EBC_DIV_2: s_next.div = s_next.tick ? s_next.dcnt[0] : s_reg.div;
      default: s_next.div = s_next.tick ? s_next.dcnt[1] : s_reg.div;
    endcase
    if (rst) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign io.tick = s_reg.tick;
  assign io.full_clk = s_reg.full;
  assign io.div_clk = s_reg.div;

endmodule

//--- rtl/ebc_strobe_mux.sv
`timescale 1ns/1ps
`include "ebc_map.svh"

module ebc_strobe_mux (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Core link
  ebc_core_if.mux_mp io
);
  import ebc_pkg::*;

  ebc_mux_state_t s_reg;
  ebc_mux_state_t s_next;
  logic a_rd;
  logic a_oe;
  logic a_we;
  logic a_fifo;

  // ========================================================================
  // Pin steering by memory type, updated on bus clock edges only
  always_comb begin
    s_next = s_reg;
    a_rd = 1'b0;
    a_oe = 1'b0;
    a_we = 1'b0;
    a_fifo = 1'b0;
    if (io.acc_active) begin
      case (io.acc_mem)
        EBC_MEM_ASYNC: begin
          a_rd = io.strobes.async_re;
          a_oe = io.strobes.async_oe;
          a_we = io.strobes.async_we;
        end
        EBC_MEM_SDRAM: begin
          a_rd = io.strobes.sdram_cas;
          a_oe = io.strobes.sdram_ras;
          a_we = io.strobes.sdram_we;
        end
        EBC_MEM_SYNC: begin
          a_rd = io.ren_sel ? io.strobes.sync_re : io.strobes.sync_ads;
          a_oe = io.strobes.sync_oe;
          a_we = io.strobes.sync_we;
          a_fifo = (io.acc_space == `EBC_FIFO_SPACE) && io.strobes.sync_oe;
        end
        default: begin
          a_rd = 1'b0;
        end
      endcase
    end
    if (io.tick) begin
      s_next.rd_n = ~a_rd;
      s_next.oe_n = ~a_oe;
      s_next.we_n = ~a_we;
      s_next.fifo_oe_n = ~a_fifo;
    end
    if (rst) begin
      s_next = '1;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign io.rd_n = s_reg.rd_n;
  assign io.oe_n = s_reg.oe_n;
  assign io.we_n = s_reg.we_n;
  assign io.fifo_oe_n = s_reg.fifo_oe_n;

endmodule

//--- rtl/ebc_top.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ebc_map.svh"

// Functional notes
// - Divided clock out: input clock over 1/2/4.
// - Full-rate clock out follows selected input clock.
// - Sync mode: select bit picks strobe or read.
// - Read pin: async read, column strobe, sync.
// - Output pin: async enable, row strobe, sync.
// - Write pin: async, SDRAM or sync write.
// - Dedicated sync output enable for space three.
// - Address pins drive accesses, sampled at reset.
// - Endian strap latched: one means little endian.
// - Boot mode strap latched, default ROM boot.
// - Primary bus clock select strap latched.
// - Secondary bus clock select strap latched.
module ebc_top #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input logic REF_CLK,
  input logic RST,
  // Register port
  input logic [7:0] REG_ADDR,
  input logic [31:0] REG_WDATA,
  input logic REG_WE,
  input logic REG_RE,
  output logic [31:0] REG_RDATA,
  // Bus engine requests
  input logic ACC_ACTIVE,
  input logic [1:0] ACC_SPACE,
  input logic [ADDR_W-1:0] ACC_ADDR,
  input logic ASYNC_READ_ENABLE,
  input logic SDRAM_COLUMN_STROBE,
  input logic SYNC_ADDRESS_STROBE,
  input logic SYNC_READ_ENABLE,
  input logic ASYNC_OUTPUT_ENABLE,
  input logic SDRAM_ROW_STROBE,
  input logic SYNC_OUTPUT_ENABLE,
  input logic ASYNC_WRITE_ENABLE,
  input logic SDRAM_WRITE_ENABLE,
  input logic SYNC_WRITE_ENABLE,
  // Board pins
  input logic SECONDARY_BUS_EXT_CLOCK_IN,
  input logic ASYNC_READY_IN,
  input logic [ADDR_W-1:0] ADDR_PIN_IN,
  output logic [ADDR_W-1:0] ADDR_PIN_OUT,
  output logic ADDR_PIN_OE,
  output logic BUS_FULL_RATE_CLOCK_OUT,
  output logic BUS_DIVIDED_CLOCK_OUT,
  output logic READ_STROBE_PIN_N,
  output logic OUTPUT_STROBE_PIN_N,
  output logic WRITE_STROBE_PIN_N,
  output logic FIFO_SPACE_OUTPUT_ENABLE_N,
  // Latched configuration
  output logic ENDIAN_LITTLE,
  output logic [1:0] BOOT_MODE,
  output logic [1:0] PRIMARY_CLOCK_SOURCE_SELECT,
  output logic [1:0] SECONDARY_CLOCK_SOURCE_SELECT,
  output ebc_pkg::ebc_src_t SECONDARY_CLOCK_SOURCE,
  output logic CONFIG_VALID,
  output logic ASYNC_READY_SYNC
);
  import ebc_pkg::*;
  // Chip-enable spaces behind this bus.
  localparam int SPACES = 4;

  // ========================================================================
  // Parameter check
  generate
    if (ADDR_W < `EBC_STRAP_MIN_W) begin : g_bad_width
      $error("ebc_top: ADDR_W too small to carry the strap pins");
    end
    if (`EBC_SPACE_REN_LSB + SPACES > `EBC_SPACE_CTRL_W) begin : g_bad_map
      $error("ebc_top: space control word too narrow for all spaces");
    end
  endgenerate

  // ========================================================================
  // State
  typedef struct packed {
    logic [ADDR_W-1:0] ea_s1;
    logic [ADDR_W-1:0] ea_s2;
    logic clk_s1;
    logic clk_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic endian;
    logic [1:0] boot;
    logic [1:0] psel;
    logic [1:0] ssel;
    logic done;
    ebc_src_t src;
    ebc_div_t ratio;
    logic [`EBC_SPACE_CTRL_W-1:0] space_ctrl;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] ea_out;
    logic ea_oe;
  } ebc_top_state_t;

  ebc_top_state_t s_reg;
  ebc_top_state_t s_next;
  ebc_core_if io ();
  logic acc_go;
  ebc_mem_t space_mem [SPACES];
  logic space_ren [SPACES];
  logic strap_endian;
  logic [1:0] strap_boot;
  logic [1:0] strap_psel;
  logic [1:0] strap_ssel;

  // ========================================================================
  // Per-space decode of memory type and read-enable select
  generate
    for (genvar i = 0; i < SPACES; i++) begin : g_space
      assign space_mem[i] = ebc_mem_t'(
        s_reg.space_ctrl[`EBC_SPACE_TYPE_LSB + 2 * i +: 2]);
      assign space_ren[i] = s_reg.space_ctrl[`EBC_SPACE_REN_LSB + i];
    end
  endgenerate

  // An access is only honoured once the straps are in.
  assign acc_go = ACC_ACTIVE && s_reg.done;

  // ========================================================================
  // Strap fields on the synchronised address pins
  // Only the second synchroniser stage is read, so no field can be
  // taken from a pin that is still settling.
  assign strap_endian = s_reg.ea_s2[`EBC_STRAP_ENDIAN];
  assign strap_boot = s_reg.ea_s2[`EBC_STRAP_BOOT_LSB +: 2];
  assign strap_psel = s_reg.ea_s2[`EBC_STRAP_PSEL_LSB +: 2];
  assign strap_ssel = s_reg.ea_s2[`EBC_STRAP_SSEL_LSB +: 2];

  // ========================================================================
  // Submodules
  ebc_clk_gen u_clk_gen (
    .clk(REF_CLK),
    .rst(RST),
    .io(io.clk_mp)
  );

  ebc_strobe_mux u_strobe_mux (
    .clk(REF_CLK),
    .rst(RST),
    .io(io.mux_mp)
  );

  // ========================================================================
  // Core link drive
  assign io.src_sel = s_reg.src;
  assign io.ratio = s_reg.ratio;
  assign io.ext_level = s_reg.clk_s2;
  assign io.acc_active = acc_go;
  assign io.acc_space = ACC_SPACE;
  assign io.acc_mem = space_mem[ACC_SPACE];
  assign io.ren_sel = space_ren[ACC_SPACE];
  assign io.strobes = '{
    async_re: ASYNC_READ_ENABLE,
    sdram_cas: SDRAM_COLUMN_STROBE,
    sync_ads: SYNC_ADDRESS_STROBE,
    sync_re: SYNC_READ_ENABLE,
    async_oe: ASYNC_OUTPUT_ENABLE,
    sdram_ras: SDRAM_ROW_STROBE,
    sync_oe: SYNC_OUTPUT_ENABLE,
    async_we: ASYNC_WRITE_ENABLE,
    sdram_we: SDRAM_WRITE_ENABLE,
    sync_we: SYNC_WRITE_ENABLE
  };

  // ========================================================================
  // Next state
  // Synchronisers keep running through reset so that the straps are
  // settled by the time reset is released.
  always_comb begin
    s_next = s_reg;
    s_next.ea_s1 = ADDR_PIN_IN;
    s_next.ea_s2 = s_reg.ea_s1;
    s_next.clk_s1 = SECONDARY_BUS_EXT_CLOCK_IN;
    s_next.clk_s2 = s_reg.clk_s1;
    // Ready is only synchronised and reported; wait states are the
    // engine's business, so no stall logic sits here.
    s_next.rdy_s1 = ASYNC_READY_IN;
    s_next.rdy_s2 = s_reg.rdy_s1;

    // Straps are taken once, in the first cycle after reset release.
    if (!s_reg.done) begin
      s_next.endian = strap_endian;
      s_next.boot = strap_boot;
      s_next.psel = strap_psel;
      s_next.ssel = strap_ssel;
      case (strap_ssel)
        2'h1: begin
          s_next.src = EBC_SRC_CPU4;
        end
        2'h2: begin
          s_next.src = EBC_SRC_CPU6;
        end
        default: begin
          s_next.src = EBC_SRC_EXT;
        end
      endcase
      s_next.done = 1'b1;
    end

    // Address pins only drive once the straps are in.
    // Between accesses they are released to the board's resistors.
    if (io.tick) begin
      s_next.ea_oe = acc_go;
      if (acc_go) begin
        s_next.ea_out = ACC_ADDR;
      end
    end

    // Register writes.
    // A reserved ratio code is ignored and the old ratio kept.
    if (REG_WE) begin
      case (REG_ADDR)
        `EBC_OFS_CLK_CTRL: begin
          if (REG_WDATA[`EBC_CLK_RATIO_LSB +: 2] != `EBC_RATIO_RESERVED) begin
            s_next.ratio = ebc_div_t'(REG_WDATA[`EBC_CLK_RATIO_LSB +: 2]);
          end
        end
        `EBC_OFS_SPACE_CTRL: begin
          s_next.space_ctrl = REG_WDATA[`EBC_SPACE_CTRL_W-1:0];
        end
        default: begin
          s_next.space_ctrl = s_reg.space_ctrl;
        end
      endcase
    end

    // Register reads, valid for the one cycle after the strobe.
    s_next.rdata = 32'h0000_0000;
    if (REG_RE) begin
      case (REG_ADDR)
        `EBC_OFS_CLK_CTRL: begin
          s_next.rdata[`EBC_CLK_RATIO_LSB +: 2] = s_reg.ratio;
        end
        `EBC_OFS_SPACE_CTRL: begin
          s_next.rdata[`EBC_SPACE_CTRL_W-1:0] = s_reg.space_ctrl;
        end
        `EBC_OFS_STRAP_STAT: begin
          s_next.rdata[`EBC_STAT_ENDIAN] = s_reg.endian;
          s_next.rdata[`EBC_STAT_BOOT_LSB +: 2] = s_reg.boot;
          s_next.rdata[`EBC_STAT_PSEL_LSB +: 2] = s_reg.psel;
          s_next.rdata[`EBC_STAT_SSEL_LSB +: 2] = s_reg.ssel;
          s_next.rdata[`EBC_STAT_DONE] = s_reg.done;
          s_next.rdata[`EBC_STAT_READY] = s_reg.rdy_s2;
          s_next.rdata[`EBC_STAT_SRC_LSB +: 2] = s_reg.src;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (RST) begin
      // Straps fall back to their pull defaults until sampled again.
      s_next.endian = `EBC_RST_ENDIAN;
      s_next.boot = `EBC_RST_BOOT;
      s_next.psel = `EBC_RST_PSEL;
      s_next.ssel = `EBC_RST_SSEL;
      s_next.done = 1'b0;
      s_next.src = EBC_SRC_EXT;
      s_next.ratio = EBC_DIV_1;
      s_next.space_ctrl = `EBC_RST_SPACE_CTRL;
      s_next.rdata = 32'h0000_0000;

      // Address pins are released so the straps read clean.
      s_next.ea_out = '0;
      s_next.ea_oe = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    s_reg <= s_next;
  end

  // ========================================================================
  // Outputs
  assign REG_RDATA = s_reg.rdata;
  assign ADDR_PIN_OUT = s_reg.ea_out;
  assign ADDR_PIN_OE = s_reg.ea_oe;

  // Bus clocks and strobe pins.
  assign BUS_FULL_RATE_CLOCK_OUT = io.full_clk;
  assign BUS_DIVIDED_CLOCK_OUT = io.div_clk;
  assign READ_STROBE_PIN_N = io.rd_n;
  assign OUTPUT_STROBE_PIN_N = io.oe_n;
  assign WRITE_STROBE_PIN_N = io.we_n;
  assign FIFO_SPACE_OUTPUT_ENABLE_N = io.fifo_oe_n;

  // Latched configuration and ready.
  assign ENDIAN_LITTLE = s_reg.endian;
  assign BOOT_MODE = s_reg.boot;
  assign PRIMARY_CLOCK_SOURCE_SELECT = s_reg.psel;
  assign SECONDARY_CLOCK_SOURCE_SELECT = s_reg.ssel;
  assign SECONDARY_CLOCK_SOURCE = s_reg.src;
  assign CONFIG_VALID = s_reg.done;
  assign ASYNC_READY_SYNC = s_reg.rdy_s2;

endmodule

//--- tb/ebc_mem_model.sv
`timescale 1ns/1ps

module ebc_mem_model (
  // Clock
  input logic clk,
  // Board straps and memory pace
  input logic [6:0] strap,
  input logic slow,
  // Device pins
  input logic [19:0] addr_out,
  input logic addr_oe,
  input logic rd_n,
  output logic [19:0] addr_in,
  output logic ready
);
  // ==========
  // Pins
  // Released pins fall back to the resistors, so a stale address never
  // reads as a strap; the board straps no reserved code.
  assign addr_in = addr_oe ? addr_out : {strap, 13'h0000};
  // A slow memory holds ready low while the read strobe is low.
  always_ff @(posedge clk) begin
    ready <= !(slow && !rd_n);
  end
endmodule

//--- tb/ebc_top_monitor.sv
`timescale 1ns/1ps

module ebc_top_monitor
  import ebc_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input logic REF_CLK,
  input logic RST,
  // Bus engine requests
  input logic ACC_ACTIVE,
  input logic [1:0] ACC_SPACE,
  input logic [ADDR_W-1:0] ACC_ADDR,
  input logic ASYNC_READ_ENABLE,
  input logic SDRAM_COLUMN_STROBE,
  input logic SYNC_ADDRESS_STROBE,
  input logic SYNC_READ_ENABLE,
  input logic ASYNC_OUTPUT_ENABLE,
  input logic SDRAM_ROW_STROBE,
  input logic SYNC_OUTPUT_ENABLE,
  input logic ASYNC_WRITE_ENABLE,
  input logic SDRAM_WRITE_ENABLE,
  input logic SYNC_WRITE_ENABLE,
  // Pins
  input logic [ADDR_W-1:0] ADDR_PIN_OUT,
  input logic ADDR_PIN_OE,
  input logic BUS_FULL_RATE_CLOCK_OUT,
  input logic BUS_DIVIDED_CLOCK_OUT,
  input logic READ_STROBE_PIN_N,
  input logic OUTPUT_STROBE_PIN_N,
  input logic WRITE_STROBE_PIN_N,
  input logic FIFO_SPACE_OUTPUT_ENABLE_N,
  // Configuration
  input logic ENDIAN_LITTLE,
  input logic [1:0] BOOT_MODE,
  input logic [1:0] PRIMARY_CLOCK_SOURCE_SELECT,
  input logic [1:0] SECONDARY_CLOCK_SOURCE_SELECT,
  input ebc_pkg::ebc_src_t SECONDARY_CLOCK_SOURCE,
  input logic CONFIG_VALID
);
  import ebc_pkg::*;

  // ==========
  // Helpers
  logic full, rd_req, oe_req, we_req, ff_req;
  assign full = BUS_FULL_RATE_CLOCK_OUT;
  assign rd_req = ACC_ACTIVE && (ASYNC_READ_ENABLE || SDRAM_COLUMN_STROBE
    || SYNC_ADDRESS_STROBE || SYNC_READ_ENABLE);
  assign oe_req = ACC_ACTIVE && (ASYNC_OUTPUT_ENABLE || SDRAM_ROW_STROBE
    || SYNC_OUTPUT_ENABLE);
  assign we_req = ACC_ACTIVE && (ASYNC_WRITE_ENABLE || SDRAM_WRITE_ENABLE
    || SYNC_WRITE_ENABLE);
  assign ff_req = ACC_ACTIVE && ACC_SPACE == 2'h3 && SYNC_OUTPUT_ENABLE;

  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // ==========
  // Sequences
  // Pins move one cycle after the bus clock rose, never elsewhere.
  sequence s_launch;
    $past(full) && !$past(full, 2);
  endsequence
  sequence s_cpu4;
    full [*2] ##1 !full [*2] ##1 full;
  endsequence
  sequence s_cpu6;
    full [*3] ##1 !full [*3] ##1 full;
  endsequence

  // ==========
  // Assertions
  a_cpu4_shape: assert property ($past(CONFIG_VALID, 8) &&
    SECONDARY_CLOCK_SOURCE == EBC_SRC_CPU4 && $rose(full) |-> s_cpu4)
    else $error("cpu4 bus clock shape wrong");
  a_cpu6_shape: assert property ($past(CONFIG_VALID, 8) &&
    SECONDARY_CLOCK_SOURCE == EBC_SRC_CPU6 && $rose(full) |-> s_cpu6)
    else $error("cpu6 bus clock shape wrong");
  a_div_edge: assert property ($rose(BUS_DIVIDED_CLOCK_OUT) |->
    $rose(full)) else $error("divided clock off full clock edge");
  a_read_cause: assert property ($fell(READ_STROBE_PIN_N) |->
    s_launch ##0 $past(rd_req)) else $error("read pin fell unasked");
  a_oe_cause: assert property ($fell(OUTPUT_STROBE_PIN_N) |->
    s_launch ##0 $past(oe_req)) else $error("output pin fell unasked");
  a_we_cause: assert property ($fell(WRITE_STROBE_PIN_N) |->
    s_launch ##0 $past(we_req)) else $error("write pin fell unasked");
  a_fifo_space: assert property ($fell(FIFO_SPACE_OUTPUT_ENABLE_N) |->
    s_launch ##0 $past(ff_req)) else $error("fifo enable fell unasked");
  a_addr_drive: assert property ($rose(ADDR_PIN_OE) |-> CONFIG_VALID &&
    ADDR_PIN_OUT == $past(ACC_ADDR)) else $error("address pins wrong");
  a_cfg_stable: assert property (CONFIG_VALID && $past(CONFIG_VALID) |->
    $stable(ENDIAN_LITTLE) && $stable(BOOT_MODE) &&
    $stable(PRIMARY_CLOCK_SOURCE_SELECT) &&
    $stable(SECONDARY_CLOCK_SOURCE_SELECT))
    else $error("latched straps changed");
  a_src_decode: assert property (CONFIG_VALID |->
    SECONDARY_CLOCK_SOURCE == (SECONDARY_CLOCK_SOURCE_SELECT == 2'h1 ?
    EBC_SRC_CPU4 : SECONDARY_CLOCK_SOURCE_SELECT == 2'h2 ? EBC_SRC_CPU6 :
    EBC_SRC_EXT)) else $error("clock source decode wrong");
endmodule

bind ebc_top ebc_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

//--- tb/ebc_top_tb.sv
`timescale 1ns/1ps

module ebc_top_tb;
  import ebc_pkg::*;

  // ==========
  // Signals
  logic REF_CLK = 1'b0, RST = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
  logic ACC_ACTIVE = 1'b0, ext_clk = 1'b0, slow = 1'b0, ready;
  logic [1:0] ACC_SPACE = 2'h0, BOOT_MODE, PRIMARY_CLOCK_SOURCE_SELECT;
  logic [1:0] SECONDARY_CLOCK_SOURCE_SELECT;
  logic [19:0] ACC_ADDR = 20'h0, ADDR_PIN_OUT, addr_in;
  logic [6:0] strap = 7'h60;
  ebc_strobe_t stb = '0;
  ebc_src_t SECONDARY_CLOCK_SOURCE;
  logic ADDR_PIN_OE, BUS_FULL_RATE_CLOCK_OUT, BUS_DIVIDED_CLOCK_OUT;
  logic READ_STROBE_PIN_N, OUTPUT_STROBE_PIN_N, WRITE_STROBE_PIN_N;
  logic FIFO_SPACE_OUTPUT_ENABLE_N, ENDIAN_LITTLE, CONFIG_VALID;
  logic ASYNC_READY_SYNC;
  int error_cnt = 0, cmp_count = 0;

  initial begin
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // A 60 ns external clock, off the reference edges, gives 12 cycles.
  initial begin
    #2.3;
    forever #30 ext_clk = ~ext_clk;
  end

  ebc_top dut (
    .*,
    .ASYNC_READ_ENABLE(stb.async_re),
    .SDRAM_COLUMN_STROBE(stb.sdram_cas),
    .SYNC_ADDRESS_STROBE(stb.sync_ads),
    .SYNC_READ_ENABLE(stb.sync_re),
    .ASYNC_OUTPUT_ENABLE(stb.async_oe),
    .SDRAM_ROW_STROBE(stb.sdram_ras),
    .SYNC_OUTPUT_ENABLE(stb.sync_oe),
    .ASYNC_WRITE_ENABLE(stb.async_we),
    .SDRAM_WRITE_ENABLE(stb.sdram_we),
    .SYNC_WRITE_ENABLE(stb.sync_we),
    .SECONDARY_BUS_EXT_CLOCK_IN(ext_clk),
    .ASYNC_READY_IN(ready),
    .ADDR_PIN_IN(addr_in)
  );

  ebc_mem_model mem (
    .clk(REF_CLK),
    .strap(strap),
    .slow(slow),
    .addr_out(ADDR_PIN_OUT),
    .addr_oe(ADDR_PIN_OE),
    .rd_n(READ_STROBE_PIN_N),
    .addr_in(addr_in),
    .ready(ready)
  );

  // ==========
  // Shared tasks
  task print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1'b1;
    @(posedge REF_CLK);
    REG_WE <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RE <= 1'b1;
    @(posedge REF_CLK);
    REG_RE <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask

  // Bounded wait for a level on the full (d=0) or divided (d=1) clock.
  task wait_sig(input logic d, input logic v, output int n);
    n = 0;
    do begin
      @(posedge REF_CLK);
      #1;
      n++;
    end while ((d ? BUS_DIVIDED_CLOCK_OUT : BUS_FULL_RATE_CLOCK_OUT) !== v
      && n < 200);
    if (n >= 200) begin
      error_cnt++;
      $display("bus clock wait ran out");
      print_verdict();
    end
  endtask

  task measure(input logic d, output int p);
    int k, k1;
    wait_sig(d, 1'b0, k);
    wait_sig(d, 1'b1, k);
    wait_sig(d, 1'b0, k1);
    wait_sig(d, 1'b1, k);
    p = k1 + k;
  endtask

  // Ends just after the edge that follows the one that launches pins for the tick.
  task bus_edge();
    int k;
    wait_sig(1'b0, 1'b0, k);
    wait_sig(1'b0, 1'b1, k);
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask

  task wait_rdy(input logic v);
    int n;
    logic [31:0] d;
    n = 0;
    while (ASYNC_READY_SYNC !== v && n < 8) begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    chk(ASYNC_READY_SYNC, v);
    rd(8'h08, d);
    chk(d[8], v);
  endtask

  // ==========
  // Scenarios
  task t_straps(input logic [6:0] s);
    logic [31:0] d;
    @(posedge REF_CLK);
    strap <= s;
    RST <= 1'b1;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1;
    chk({CONFIG_VALID, ENDIAN_LITTLE, BOOT_MODE, PRIMARY_CLOCK_SOURCE_SELECT,
      SECONDARY_CLOCK_SOURCE_SELECT}, {1'b1, s});
    chk(SECONDARY_CLOCK_SOURCE, s[1:0]);
    rd(8'h08, d);
    chk(d, {21'h0, s[1:0], 2'h3, s[1:0], s[3:2], s[5:4], s[6]});
    rd(8'h0C, d);
    chk(d, 32'h0);
    $display("strap test done");
  endtask

  task t_clocks(input int fp);
    int p, r;
    logic [31:0] d;
    measure(1'b0, p);
    chk(p, fp);
    for (r = 0; r < 4; r++) begin
      wr(8'h00, r);
      measure(1'b1, p);
      measure(1'b1, p);
      chk(p, fp << (r == 3 ? 2 : r));
    end
    rd(8'h00, d);
    chk(d, 32'h2);
    wr(8'h00, 32'h0);
    $display("clock test done");
  endtask

  task t_strobes();
    int m, sp, b;
    logic [1:0] ty;
    logic rn, r, o, w, f;
    ebc_strobe_t s;
    for (m = 0; m < 5; m++) begin
      ty = (m == 4) ? 2'h2 : m[1:0];
      rn = (m == 4);
      wr(8'h04, {20'h0, {4{rn}}, {4{ty}}});
      for (sp = 0; sp < 4; sp += 3) begin
        for (b = 0; b < 10; b++) begin
          s = ebc_strobe_t'(10'h200 >> b);
          @(posedge REF_CLK);
          ACC_ACTIVE <= 1'b1;
          ACC_SPACE <= sp[1:0];
          ACC_ADDR <= {12'h5A0, m[3:0], b[3:0]};
          stb <= s;
          bus_edge();
          r = (ty == 2'h0 && s.async_re) || (ty == 2'h1 && s.sdram_cas) ||
            (ty == 2'h2 && (rn ? s.sync_re : s.sync_ads));
          o = (ty == 2'h0 && s.async_oe) || (ty == 2'h1 && s.sdram_ras) ||
            (ty == 2'h2 && s.sync_oe);
          w = (ty == 2'h0 && s.async_we) || (ty == 2'h1 && s.sdram_we) ||
            (ty == 2'h2 && s.sync_we);
          f = sp == 3 && ty == 2'h2 && s.sync_oe;
          chk({READ_STROBE_PIN_N, OUTPUT_STROBE_PIN_N, WRITE_STROBE_PIN_N,
            FIFO_SPACE_OUTPUT_ENABLE_N}, {!r, !o, !w, !f});
          if (m != 3) begin
            chk({ADDR_PIN_OE, ADDR_PIN_OUT}, {1'b1, 12'h5A0, m[3:0], b[3:0]});
          end
        end
      end
    end
    @(posedge REF_CLK);
    ACC_ACTIVE <= 1'b0;
    stb <= '0;
    bus_edge();
    chk({ADDR_PIN_OE, READ_STROBE_PIN_N, OUTPUT_STROBE_PIN_N,
      WRITE_STROBE_PIN_N, FIFO_SPACE_OUTPUT_ENABLE_N}, 5'h0F);
    $display("strobe test done");
  endtask

  task t_ready();
    wr(8'h04, 32'h0);
    @(posedge REF_CLK);
    slow <= 1'b1;
    ACC_ACTIVE <= 1'b1;
    stb <= ebc_strobe_t'(10'h200);
    bus_edge();
    wait_rdy(1'b0);
    @(posedge REF_CLK);
    slow <= 1'b0;
    ACC_ACTIVE <= 1'b0;
    stb <= '0;
    wait_rdy(1'b1);
    $display("ready test done");
  endtask

  // ==========
  // Main sequence
  initial begin
    t_straps(7'h60);
    t_clocks(12);
    t_straps(7'h1A);
    t_clocks(6);
    t_straps(7'h45);
    t_clocks(4);
    t_strobes();
    t_ready();
    print_verdict();
  end
endmodule
